// [sfa_aux_ctrl.sv]
`include "sfa_regs.svh"
`default_nettype none
module sfa_aux_ctrl #(
  parameter int unsigned QUEUE_DEPTH = 4
) (
  input  wire logic            CORE_CLK,
  input  wire logic            ARST_N,
  input  wire logic            HSEL,
  input  wire logic [31:0]     HADDR,
  input  wire logic [1:0]      HTRANS,
  input  wire logic            HWRITE,
  input  wire logic [2:0]      HSIZE,
  input  wire logic [31:0]     HWDATA,
  input  wire logic            HREADY,
  output logic      [31:0]     HRDATA,
  output logic                 HREADYOUT,
  output logic                 HRESP,
  input  wire sfa_pkg::sfa_rx_s RX_IN,
  input  wire sfa_pkg::sfa_tx_s TX_IN,
  output logic                 SERIAL_TX_LINE,
  output logic                 REQUEST_TO_SEND_PIN_N,
  output logic                 RX_LOAD_OK,
  output logic                 TX_OPEN_FLAG,
  output logic                 TX_UNDERRUN,
  output logic                 IRQ
);
  import sfa_pkg::*;

  if (QUEUE_DEPTH < 2) begin : g_bad_depth
    $error("QUEUE_DEPTH must be at least 2");
  end

  sfa_bus_e              bus_st;
  logic [7:0]            a_idx;
  logic                  a_ok;
  logic                  a_wr;
  logic                  accept;
  logic                  wr_en;
  logic                  rd_en;
  logic [7:0]            aux;
  logic [7:0]            ien;
  logic [7:0]            sync_hi;
  logic [2:0]            mode;
  logic                  rts_req;
  logic [`SFA_EV_W-1:0]  evt_stat;
  logic [`SFA_EV_W-1:0]  evt_en;
  logic [`SFA_EV_W-1:0]  ev_set;
  logic [`SFA_EV_W-1:0]  clr_mask;
  logic [31:0]           rd_val;
  logic                  bank;
  logic                  qen;
  logic                  sdlc;
  logic                  nrzi;
  logic                  q_push;
  logic                  q_pop;
  logic [SFA_CNT_W-1:0]  q_head;
  logic                  q_ne;
  logic                  q_full;
  logic                  q_ovf;
  logic                  rts_auto;
  logic                  mode_wr;

  assign bank = ien[`SFA_BANK_BIT];
  assign qen  = ien[`SFA_QEN_BIT];
  assign sdlc = mode[`SFA_MODE_SDLC_BIT];
  assign nrzi = mode[`SFA_MODE_NRZI_BIT];

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // one wait state per transfer so reads see writes just before them
  assign accept = HSEL && HREADY && HTRANS[1];
  assign wr_en  = (bus_st == BUS_DATA) && a_wr && a_ok;
  assign rd_en  = (bus_st == BUS_DATA) && !a_wr && a_ok;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bus_st    <= BUS_IDLE;
      HREADYOUT <= 1'b1;
      a_idx     <= 8'h00;
      a_ok      <= 1'b0;
      a_wr      <= 1'b0;
      HRESP     <= 1'b0;
    end else begin
      case (bus_st)
        BUS_IDLE: begin
          if (accept) begin
            bus_st    <= BUS_DATA;
            HREADYOUT <= 1'b0;
            a_idx     <= HADDR[9:2];
            a_ok      <= (HADDR[31:10] == 22'h0) && (HADDR[1:0] == 2'h0);
            a_wr      <= HWRITE;
          end
        end
        default: begin
          bus_st    <= BUS_IDLE;
          HREADYOUT <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HRDATA <= 32'h0;
    end else if (rd_en) begin
      HRDATA <= rd_val;
    end
  end

  always_comb begin
    rd_val = 32'h0;
    if (a_idx == `SFA_IDX_STAT_LO && bank) begin
      rd_val = {24'h0, q_head[7:0]};
    end else if (a_idx == `SFA_IDX_STAT_HI && bank) begin
      rd_val = {24'h0, q_ovf, q_ne, q_head[SFA_CNT_W-1:8]};
    end else if (a_idx == `SFA_IDX_STAT_HI) begin
      rd_val = {24'h0, sync_hi};
    end else if (a_idx == `SFA_IDX_IEN_HI) begin
      rd_val = {24'h0, ien};
    end else if (a_idx == `SFA_IDX_CHAN_MODE) begin
      rd_val = {29'h0, mode};
    end else if (a_idx == `SFA_IDX_EVT_STAT) begin
      rd_val = {28'h0, evt_stat};
    end else if (a_idx == `SFA_IDX_EVT_EN) begin
      rd_val = {28'h0, evt_en};
    end else if (a_idx == `SFA_IDX_LINK_STAT) begin
      rd_val = {28'h0, TX_UNDERRUN, rts_req, q_full, q_ne};
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // banked write at 0x07
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aux     <= `SFA_AUX_RST;
      sync_hi <= `SFA_SYNC_RST;
      ien     <= `SFA_IEN_RST;
    end else if (wr_en) begin
      if (a_idx == `SFA_IDX_AUX && bank) begin
        aux <= HWDATA[7:0];
      end else if (a_idx == `SFA_IDX_AUX) begin
        sync_hi <= HWDATA[7:0];
      end else if (a_idx == `SFA_IDX_IEN_HI) begin
        ien <= HWDATA[7:0];
      end
    end
  end

  assign mode_wr = wr_en && (a_idx == `SFA_IDX_CHAN_MODE);
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode <= `SFA_MODE_RST;
    end else if (mode_wr) begin
      mode <= HWDATA[2:0];
    end
  end

  // ---------------------------------------------------------------
  // frame status queue
  // ---------------------------------------------------------------
  // one entry per frame while enabled and the queue is not full
  assign q_push = qen && RX_IN.frame_end;
  assign q_pop  = rd_en && bank && (a_idx == `SFA_IDX_STAT_LO);

  sfa_status_fifo #(
    .WIDTH (SFA_CNT_W),
    .DEPTH (QUEUE_DEPTH)
  ) u_queue (
    .clk       (CORE_CLK),
    .arst_n    (ARST_N),
    .flush     (!qen),
    .push      (q_push),
    .push_data (RX_IN.byte_count),
    .pop       (q_pop),
    .head      (q_head),
    .not_empty (q_ne),
    .full      (q_full),
    .overflow  (q_ovf)
  );

  // ---------------------------------------------------------------
  // automatic link behaviours
  // ---------------------------------------------------------------
  // hold receive load
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RX_LOAD_OK <= 1'b1;
    end else begin
      RX_LOAD_OK <= !aux[`SFA_AUX_WAIT_BIT] || RX_IN.crc_done;
    end
  end
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SERIAL_TX_LINE <= 1'b1;
    end else if (aux[`SFA_AUX_IDLE_BIT] && sdlc && nrzi &&
                 !TX_IN.enabled) begin
      SERIAL_TX_LINE <= 1'b1;
    end else begin
      SERIAL_TX_LINE <= TX_IN.data;
    end
  end
  // auto release
  // a software write in the same cycle wins over the release
  assign rts_auto = aux[`SFA_AUX_RTS_BIT] && sdlc && TX_IN.close_flag_done;
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rts_req <= 1'b0;
    end else if (mode_wr) begin
      rts_req <= HWDATA[`SFA_MODE_RTS_BIT];
    end else if (rts_auto) begin
      rts_req <= 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REQUEST_TO_SEND_PIN_N <= 1'b1;
    end else begin
      REQUEST_TO_SEND_PIN_N <= !rts_req;
    end
  end
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_UNDERRUN <= 1'b0;
    end else if (TX_IN.underrun) begin
      TX_UNDERRUN <= 1'b1;
    end else if (aux[`SFA_AUX_UNDR_BIT] && sdlc && TX_IN.first_byte_sent) begin
      TX_UNDERRUN <= 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_OPEN_FLAG <= 1'b0;
    end else begin
      TX_OPEN_FLAG <= TX_IN.frame_start && aux[`SFA_AUX_FLAG_BIT] && sdlc;
    end
  end

  // ---------------------------------------------------------------
  // events and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    ev_set                = '0;
    ev_set[`SFA_EV_PUSH]  = q_push && !q_full;
    ev_set[`SFA_EV_OVF]   = q_push && q_full;
    ev_set[`SFA_EV_UNDR]  = TX_IN.underrun;
    ev_set[`SFA_EV_RTS]   = rts_auto && rts_req && !mode_wr;
  end
  assign clr_mask = (wr_en && a_idx == `SFA_IDX_EVT_CLR) ?
                    HWDATA[`SFA_EV_W-1:0] : '0;
  // new events win over a clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      evt_stat <= `SFA_EV_RST;
    end else begin
      evt_stat <= (evt_stat & ~clr_mask) | ev_set;
    end
  end
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      evt_en <= `SFA_EV_RST;
    end else if (wr_en && a_idx == `SFA_IDX_EVT_EN) begin
      evt_en <= HWDATA[`SFA_EV_W-1:0];
    end
  end
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(evt_stat & evt_en);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  aux_write_a: assert property (
    wr_en && a_idx == `SFA_IDX_AUX && bank |=>
      aux == $past(HWDATA[7:0]) && $stable(sync_hi))
    else $error("aux register missed a banked write");
  sync_write_a: assert property (
    wr_en && a_idx == `SFA_IDX_AUX && !bank |=>
      sync_hi == $past(HWDATA[7:0]) && $stable(aux))
    else $error("sync register missed an unbanked write");
  ovf_flag_a: assert property (
    rd_en && bank && a_idx == `SFA_IDX_STAT_HI |=>
      HRDATA[`SFA_HI_OVF_BIT] == $past(q_ovf) && HREADYOUT)
    else $error("overflow flag read wrong");
  empty_flag_a: assert property (
    rd_en && bank && a_idx == `SFA_IDX_STAT_HI |=>
      HRDATA[`SFA_HI_NE_BIT] == $past(q_ne) &&
      HRDATA[5:0] == $past(q_head[SFA_CNT_W-1:8]))
    else $error("not-empty flag or high count read wrong");
  count_lo_a: assert property (
    rd_en && bank && a_idx == `SFA_IDX_STAT_LO |=>
      HRDATA == {24'h0, $past(q_head[7:0])})
    else $error("low count read wrong");
  crc_hold_a: assert property (
    aux[`SFA_AUX_WAIT_BIT] && !RX_IN.crc_done |=> !RX_LOAD_OK)
    else $error("receive load not held for check sequence");
  idle_high_a: assert property (
    aux[`SFA_AUX_IDLE_BIT] && sdlc && nrzi && !TX_IN.enabled
      |=> SERIAL_TX_LINE)
    else $error("idle line not held high");
  rts_release_a: assert property (
    rts_auto && !mode_wr |=> ##1 REQUEST_TO_SEND_PIN_N)
    else $error("request to send not released");
  underrun_clear_a: assert property (
    aux[`SFA_AUX_UNDR_BIT] && sdlc && TX_IN.first_byte_sent &&
      !TX_IN.underrun |=> !TX_UNDERRUN)
    else $error("underrun latch not cleared");
  open_flag_a: assert property (
    TX_IN.frame_start |=>
      TX_OPEN_FLAG == $past(aux[`SFA_AUX_FLAG_BIT] && sdlc))
    else $error("opening flag request wrong");
  bank_sel_a: assert property (
    wr_en && a_idx == `SFA_IDX_IEN_HI |=> bank == $past(HWDATA[0]))
    else $error("bank select not taken");
  queue_gate_a: assert property (
    !qen |=> !q_ne)
    else $error("disabled queue holds entries");
  queue_push_a: assert property (
    q_push && q_full && !q_pop |=> q_ovf && q_full)
    else $error("push into full queue did not flag overflow");
endmodule : sfa_aux_ctrl
`default_nettype wire

// [sfa_aux_ctrl_test.sv]
`include "sfa_regs.svh"
`default_nettype none
module sfa_aux_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sfa_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int DEPTH = 4;
  localparam int FS = 3;
  localparam int FB = 2;
  localparam int CF = 1;
  localparam int UR = 0;
  localparam logic [7:0] HI = `SFA_IDX_STAT_HI;
  localparam logic [7:0] LO = `SFA_IDX_STAT_LO;
  localparam logic [7:0] AUX = `SFA_IDX_AUX;
  localparam logic [7:0] IEN = `SFA_IDX_IEN_HI;
  localparam logic [7:0] MODE = `SFA_IDX_CHAN_MODE;
  localparam logic [7:0] EST = `SFA_IDX_EVT_STAT;
  localparam logic [7:0] ECL = `SFA_IDX_EVT_CLR;
  localparam logic [7:0] EEN = `SFA_IDX_EVT_EN;
  localparam logic [7:0] LNK = `SFA_IDX_LINK_STAT;
  typedef struct packed {
    logic       w;
    logic [7:0] idx;
    logic [7:0] d;
  } sfa_row_s;
  logic        clk, arst_n, hreadyout, hresp, txl, rts_n;
  logic        load_ok, open_flag, undr, irq, hwrite;
  logic [31:0] haddr, hwdata, hrdata, r, n;
  logic [1:0]  htrans;
  logic [7:0]  pins;
  sfa_rx_s     rx;
  sfa_tx_s     tx;
  int          bad_count, tests_run;
  sfa_row_s    rows [14] = '{'{0, HI, 8'h00}, '{1, HI, 8'hA5},
    '{0, HI, 8'hA5}, '{0, 8'h20, 8'h00}, '{1, EEN, 8'h0F}, '{0, EEN, 8'h0F},
    '{0, EST, 8'h00}, '{0, LNK, 8'h00}, '{1, IEN, 8'h05}, '{1, AUX, 8'h40},
    '{0, HI, 8'h00}, '{1, IEN, 8'h04}, '{0, HI, 8'hA5}, '{0, MODE, 8'h00}};
  // mode, aux, tx enabled, expected line, expected flag count
  logic [18:0] txc [5] = '{{8'h03, 8'h48, 3'b010}, {8'h03, 8'h49, 3'b101},
    {8'h01, 8'h49, 3'b001}, {8'h02, 8'h41, 3'b000}, {8'h03, 8'h40, 3'b000}};

  assign pins = {hreadyout, hresp, txl, rts_n, load_ok, open_flag, undr, irq};

  sfa_aux_ctrl #(.QUEUE_DEPTH(DEPTH)) dut_u (
    .CORE_CLK(clk), .ARST_N(arst_n), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .RX_IN(rx), .TX_IN(tx), .SERIAL_TX_LINE(txl),
    .REQUEST_TO_SEND_PIN_N(rts_n), .RX_LOAD_OK(load_ok),
    .TX_OPEN_FLAG(open_flag), .TX_UNDERRUN(undr), .IRQ(irq));
  sfa_far_station far_u (.core_clk(clk), .rx_in(rx), .tx_in(tx));

  initial clk = 1'b0;
  always #20 clk = ~clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    tests_run++;
    if (got !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t ns got %h expected %h", $time, got, e);
    end
  endtask : chk

  task automatic ck1(input logic got, input logic e);
    chk({31'h0, got}, {31'h0, e});
  endtask : ck1

  // bus master: hold each phase until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd);
    int k;
    k = 0;
    htrans <= 2'h2;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= w;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    // a bus that never answers counts against the run
    if (hreadyout !== 1'b1) begin
      bad_count++;
    end
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    if (hreadyout !== 1'b1) begin
      bad_count++;
    end
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e,
                     input logic [7:0] m = 8'hFF);
    xfer(1'b0, idx, 8'h00);
    chk(r & {24'h0, m}, {24'h0, e});
  endtask : rdc

  task automatic w3;
    repeat (3) @(posedge clk);
  endtask : w3

  task automatic done(input string s);
    $display("test %s ended, mismatches so far %0d", s, bad_count);
  endtask : done

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #200000;
    bad_count++;
    end_of_test;
  end

  initial begin
    arst_n = 1'b0;
    htrans = 2'h0;
    haddr = '0;
    hwrite = 1'b0;
    hwdata = '0;
    bad_count = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk({24'h0, pins}, 32'hB8);
    done("reset");
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].idx, rows[i].d);
      end else begin
        rdc(rows[i].idx, rows[i].d);
      end
    end
    done("registers");
    wr(IEN, 8'h05);
    for (int i = 0; i < DEPTH + 1; i++) begin
      far_u.end_frame(14'h3FFF - 14'(i));
    end
    w3;
    rdc(EST, 8'h03);
    ck1(irq, 1'b1);
    wr(EEN, 8'h00);
    w3;
    ck1(irq, 1'b0);
    wr(EEN, 8'h0F);
    for (int i = 0; i < DEPTH; i++) begin
      rdc(HI, 8'hFF);
      rdc(LO, 8'hFF - 8'(i));
    end
    rdc(HI, 8'h80, 8'hC0);
    wr(IEN, 8'h01);
    wr(IEN, 8'h05);
    rdc(HI, 8'h00, 8'hC0);
    wr(ECL, 8'h0F);
    rdc(EST, 8'h00);
    ck1(irq, 1'b0);
    done("queue");
    wr(AUX, 8'h60);
    far_u.set_crc(1'b0);
    w3;
    ck1(load_ok, 1'b0);
    far_u.set_crc(1'b1);
    w3;
    ck1(load_ok, 1'b1);
    far_u.set_crc(1'b0);
    wr(AUX, 8'h40);
    w3;
    ck1(load_ok, 1'b1);
    done("receive hold");
    foreach (txc[i]) begin
      wr(MODE, txc[i][18:11]);
      wr(AUX, txc[i][10:3]);
      far_u.set_tx(txc[i][2], 1'b0);
      w3;
      ck1(txl, txc[i][1]);
      n = '0;
      fork
        far_u.pulse(FS);
        repeat (5) begin
          @(posedge clk);
          n = n + open_flag;
        end
      join
      chk(n, {31'h0, txc[i][0]});
    end
    done("transmit line");
    wr(MODE, 8'h05);
    wr(AUX, 8'h40);
    far_u.pulse(CF);
    w3;
    ck1(rts_n, 1'b0);
    wr(AUX, 8'h44);
    far_u.pulse(CF);
    w3;
    ck1(rts_n, 1'b1);
    rdc(MODE, 8'h05);
    rdc(LNK, 8'h00, 8'h04);
    rdc(EST, 8'h08);
    done("request release");
    wr(AUX, 8'h40);
    far_u.pulse(UR);
    w3;
    ck1(undr, 1'b1);
    far_u.pulse(FB);
    w3;
    ck1(undr, 1'b1);
    wr(AUX, 8'h42);
    far_u.pulse(FB);
    w3;
    ck1(undr, 1'b0);
    done("underrun");
    // second reset in mid-run, events still pending
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({24'h0, pins}, 32'hB8);
    arst_n <= 1'b1;
    @(posedge clk);
    rdc(HI, 8'h00);
    done("mid reset");
    end_of_test;
  end
endmodule : sfa_aux_ctrl_test
`default_nettype wire

// [sfa_far_station.sv]
`default_nettype none
module sfa_far_station (
  input  wire logic          core_clk,
  output var  sfa_pkg::sfa_rx_s rx_in,
  output var  sfa_pkg::sfa_tx_s tx_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import sfa_pkg::*;

  initial begin
    rx_in = '0;
    tx_in = '0;
  end

  // count is only valid beside the end pulse, so it is scrambled after
  task automatic end_frame(input logic [SFA_CNT_W-1:0] cnt);
    @(posedge core_clk);
    rx_in.frame_end  <= 1'b1;
    rx_in.byte_count <= cnt;
    @(posedge core_clk);
    rx_in.frame_end  <= 1'b0;
    rx_in.byte_count <= ~cnt;
  endtask : end_frame

  task automatic set_crc(input logic v);
    @(posedge core_clk);
    rx_in.crc_done <= v;
  endtask : set_crc

  task automatic set_tx(input logic en, input logic d);
    @(posedge core_clk);
    tx_in.enabled <= en;
    tx_in.data    <= d;
  endtask : set_tx

  // one-cycle pulse on a transmitter event bit
  task automatic pulse(input int b);
    @(posedge core_clk);
    tx_in[b] <= 1'b1;
    @(posedge core_clk);
    tx_in[b] <= 1'b0;
  endtask : pulse
endmodule : sfa_far_station
`default_nettype wire

// [sfa_pkg.sv]
`default_nettype none
package sfa_pkg;
  localparam int unsigned SFA_CNT_W = 14;

  typedef struct packed {
    logic                 frame_end;
    logic [SFA_CNT_W-1:0] byte_count;
    logic                 crc_done;
  } sfa_rx_s;

  typedef struct packed {
    logic enabled;
    logic data;
    logic frame_start;
    logic first_byte_sent;
    logic close_flag_done;
    logic underrun;
  } sfa_tx_s;

  typedef enum logic {BUS_IDLE, BUS_DATA} sfa_bus_e;
endpackage : sfa_pkg
`default_nettype wire

// [sfa_regs.svh]
`ifndef SFA_REGS_SVH
`define SFA_REGS_SVH

// register indices; byte address is four times the index
`define SFA_IDX_STAT_LO   8'h06
`define SFA_IDX_STAT_HI   8'h07
`define SFA_IDX_AUX       8'h07
`define SFA_IDX_IEN_HI    8'h0F
`define SFA_IDX_CHAN_MODE 8'h10
`define SFA_IDX_EVT_STAT  8'h11
`define SFA_IDX_EVT_CLR   8'h12
`define SFA_IDX_EVT_EN    8'h13
`define SFA_IDX_LINK_STAT 8'h14

`define SFA_BANK_BIT      0
`define SFA_QEN_BIT       2
`define SFA_AUX_WAIT_BIT  5
`define SFA_AUX_IDLE_BIT  3
`define SFA_AUX_RTS_BIT   2
`define SFA_AUX_UNDR_BIT  1
`define SFA_AUX_FLAG_BIT  0
`define SFA_HI_OVF_BIT    7
`define SFA_HI_NE_BIT     6
`define SFA_MODE_SDLC_BIT 0
`define SFA_MODE_NRZI_BIT 1
`define SFA_MODE_RTS_BIT  2

`define SFA_EV_PUSH       0
`define SFA_EV_OVF        1
`define SFA_EV_UNDR       2
`define SFA_EV_RTS        3
`define SFA_EV_W          4

`define SFA_AUX_RST       8'h40
`define SFA_IEN_RST       8'h00
`define SFA_SYNC_RST      8'h00
`define SFA_MODE_RST      3'h0
`define SFA_EV_RST        4'h0

`endif

// [sfa_status_fifo.sv]
`default_nettype none
module sfa_status_fifo #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  output logic                  not_empty,
  output logic                  full,
  output logic                  overflow
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("status queue depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             do_push;
  logic             do_pop;

  assign not_empty = (wr_ptr != rd_ptr);
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) &&
                     (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign do_push   = push && !full && !flush;
  assign do_pop    = pop && not_empty && !flush;
  // empty queue reads a zero count, never a stale or unwritten slot
  assign head      = not_empty ? mem[rd_ptr[AW-1:0]] : '0;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr[AW-1:0]] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // overflow sticky
  // a flush clears the lost-entry flag unless a push into a full queue comes in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow <= 1'b0;
    end else if (push && full) begin
      overflow <= 1'b1;
    end else if (flush) begin
      overflow <= 1'b0;
    end
  end
endmodule : sfa_status_fifo
`default_nettype wire
